// ---- design/lsc_top.sv ----
`timescale 1ns/1ps
`include "lsc_consts.svh"
module lsc_top import lsc_pkg::*; (
  input wire logic clk_sys,
  input wire logic reset,
  // Avalon-MM slave
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Channel A conditions; analog ones arrive asynchronously
  input wire logic sig_det_loss_a,
  input wire logic pll_ls_lost_a,
  input wire logic pll_hs_lost_a,
  input wire logic gain_adapt_locked_a,
  input wire logic offset_cal_done_a,
  input wire logic sync_lost_a,
  input wire logic dec_err_a,
  // Channel B conditions
  input wire logic sig_det_loss_b,
  input wire logic pll_ls_lost_b,
  input wire logic pll_hs_lost_b,
  input wire logic gain_adapt_locked_b,
  input wire logic offset_cal_done_b,
  input wire logic sync_lost_b,
  input wire logic dec_err_b,
  // Datapath latency interface, core clock domain
  input wire logic link_up,
  input wire logic cfg_full_rate_4lane,
  input wire logic [9:0] measured_latency_ui,
  output logic latency_hold,
  // Pins and interrupt
  output logic loss_indicator_chan_a,
  output logic loss_indicator_chan_b,
  output logic irq
);

  // True when a latency figure sits inside the documented window
  function automatic logic lsc_in_range(input lsc_lat_t lat);
    lsc_in_range = (lat >= `LSC_LAT_MIN_UI) && (lat <= `LSC_LAT_MAX_UI);
  endfunction

  // Byte-lane merge for writable control bytes
  function automatic logic [7:0] lsc_merge(input logic [7:0] old, input logic [7:0] wd, input logic be);
    lsc_merge = be ? wd : old;
  endfunction

  lsc_chan_if ch_a ();
  lsc_chan_if ch_b ();

  logic [2*`LSC_ASYNC_W-1:0] async_in;
  logic [2*`LSC_ASYNC_W-1:0] sync1_r;
  logic [2*`LSC_ASYNC_W-1:0] sync1_nxt;
  logic [2*`LSC_ASYNC_W-1:0] sync2_r;
  logic [2*`LSC_ASYNC_W-1:0] sync2_nxt;

  lsc_en_t ctrl_a_r;
  lsc_en_t ctrl_a_nxt;
  lsc_en_t ctrl_b_r;
  lsc_en_t ctrl_b_nxt;
  logic [`LSC_IRQ_W-1:0] irq_st_r;
  logic [`LSC_IRQ_W-1:0] irq_st_nxt;
  logic [`LSC_IRQ_W-1:0] irq_mask_r;
  logic [`LSC_IRQ_W-1:0] irq_mask_nxt;
  logic [`LSC_IRQ_W-1:0] irq_set;
  logic [1:0] prev_ind_r;
  logic [1:0] prev_ind_nxt;

  logic ack_r;
  logic ack_nxt;
  logic [31:0] readdata_r;
  logic [31:0] readdata_nxt;
  logic bus_req;
  logic wr_go;

  lsc_link_t lat_state_r;
  lsc_link_t lat_state_nxt;
  lsc_lat_t lat_cap_r;
  lsc_lat_t lat_cap_nxt;
  logic range_ok_r;
  logic range_ok_nxt;
  logic capture;

  logic [31:0] status_live;
  logic [31:0] latency_word;

  // Only the analog-side flags cross a clock boundary; sync loss and decode errors are core logic
  assign async_in = {offset_cal_done_b, gain_adapt_locked_b, pll_hs_lost_b, pll_ls_lost_b, sig_det_loss_b,
                     offset_cal_done_a, gain_adapt_locked_a, pll_hs_lost_a, pll_ls_lost_a, sig_det_loss_a};

  // Two-stage synchroniser; stage one feeds stage two only
  always_comb begin
    sync1_nxt = async_in;
    sync2_nxt = sync1_r;
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      sync1_r <= 10'h000;
      sync2_r <= 10'h000;
    end else begin
      sync1_r <= sync1_nxt;
      sync2_r <= sync2_nxt;
    end
  end

  // Channel A carrier
  assign ch_a.en = ctrl_a_r;
  assign ch_a.los = sync2_r[0];
  assign ch_a.pll_ls_lost = sync2_r[1];
  assign ch_a.pll_hs_lost = sync2_r[2];
  assign ch_a.gain_adapt_locked = sync2_r[3];
  assign ch_a.offset_cal_done = sync2_r[4];
  assign ch_a.sync_lost = sync_lost_a;
  assign ch_a.dec_err = dec_err_a;

  // Channel B carrier
  assign ch_b.en = ctrl_b_r;
  assign ch_b.los = sync2_r[5];
  assign ch_b.pll_ls_lost = sync2_r[6];
  assign ch_b.pll_hs_lost = sync2_r[7];
  assign ch_b.gain_adapt_locked = sync2_r[8];
  assign ch_b.offset_cal_done = sync2_r[9];
  assign ch_b.sync_lost = sync_lost_b;
  assign ch_b.dec_err = dec_err_b;

  lsc_chan u_chan_a (
    .clk_sys(clk_sys),
    .reset(reset),
    .ch(ch_a.chan)
  );

  lsc_chan u_chan_b (
    .clk_sys(clk_sys),
    .reset(reset),
    .ch(ch_b.chan)
  );

  assign loss_indicator_chan_a = ch_a.ind;
  assign loss_indicator_chan_b = ch_b.ind;

  // Live per-channel view, same layout for both channels
  assign status_live = {16'h0000,
                        ch_b.ind, ch_b.offset_cal_done, ch_b.gain_adapt_locked, ch_b.dec_err,
                        ch_b.pll_hs_lost, ch_b.pll_ls_lost, ch_b.sync_lost, ch_b.los,
                        ch_a.ind, ch_a.offset_cal_done, ch_a.gain_adapt_locked, ch_a.dec_err,
                        ch_a.pll_hs_lost, ch_a.pll_ls_lost, ch_a.sync_lost, ch_a.los};

  assign latency_word = {14'h0000, range_ok_r, (lat_state_r == LSC_LINK_UP), 6'h00, lat_cap_r};

  // Every access costs one wait cycle so read data can come from a flop
  assign bus_req = avs_read | avs_write;
  assign avs_waitrequest = bus_req & ~ack_r;
  assign wr_go = avs_write & ack_r;
  assign avs_readdata = readdata_r;

  always_comb begin
    ack_nxt = bus_req & ~ack_r;
    readdata_nxt = readdata_r;
    if (avs_read && !ack_r) begin
      if (avs_address == `LSC_CTRL_A_OFS) begin
        readdata_nxt = {26'h0000000, ctrl_a_r};
      end else if (avs_address == `LSC_CTRL_B_OFS) begin
        readdata_nxt = {26'h0000000, ctrl_b_r};
      end else if (avs_address == `LSC_STATUS_OFS) begin
        readdata_nxt = status_live;
      end else if (avs_address == `LSC_IRQ_ST_OFS) begin
        readdata_nxt = {28'h0000000, irq_st_r};
      end else if (avs_address == `LSC_IRQ_MASK_OFS) begin
        readdata_nxt = {28'h0000000, irq_mask_r};
      end else if (avs_address == `LSC_LATENCY_OFS) begin
        readdata_nxt = latency_word;
      end else begin
        readdata_nxt = 32'h00000000;
      end
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      ack_r <= 1'b0;
      readdata_r <= 32'h00000000;
    end else begin
      ack_r <= ack_nxt;
      readdata_r <= readdata_nxt;
    end
  end

  // Each channel owns its own enables, so A and B can pick different mixes
  always_comb begin
    logic [7:0] merged;
    merged = 8'h00;
    ctrl_a_nxt = ctrl_a_r;
    ctrl_b_nxt = ctrl_b_r;
    irq_mask_nxt = irq_mask_r;
    if (wr_go) begin
      if (avs_address == `LSC_CTRL_A_OFS) begin
        merged = lsc_merge({2'b00, ctrl_a_r}, avs_writedata[7:0], avs_byteenable[0]);
        ctrl_a_nxt = merged[`LSC_EN_W-1:0];
      end else if (avs_address == `LSC_CTRL_B_OFS) begin
        merged = lsc_merge({2'b00, ctrl_b_r}, avs_writedata[7:0], avs_byteenable[0]);
        ctrl_b_nxt = merged[`LSC_EN_W-1:0];
      end else if (avs_address == `LSC_IRQ_MASK_OFS) begin
        merged = lsc_merge({4'h0, irq_mask_r}, avs_writedata[7:0], avs_byteenable[0]);
        irq_mask_nxt = merged[`LSC_IRQ_W-1:0];
      end
    end
  end

  // Enables clear at reset so no contributor reaches the pins
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      ctrl_a_r <= `LSC_CTRL_RST;
      ctrl_b_r <= `LSC_CTRL_RST;
      irq_mask_r <= `LSC_IRQ_RST;
    end else begin
      ctrl_a_r <= ctrl_a_nxt;
      ctrl_b_r <= ctrl_b_nxt;
      irq_mask_r <= irq_mask_nxt;
    end
  end

  // Latency is captured once per link establishment and then frozen
  assign capture = (lat_state_r == LSC_LINK_DOWN) && link_up;

  always_comb begin
    lat_state_nxt = lat_state_r;
    lat_cap_nxt = lat_cap_r;
    range_ok_nxt = range_ok_r;
    case (lat_state_r)
      LSC_LINK_DOWN: begin
        if (link_up) begin
          lat_state_nxt = LSC_LINK_UP;
          lat_cap_nxt = measured_latency_ui;
          range_ok_nxt = ~cfg_full_rate_4lane | lsc_in_range(measured_latency_ui);
        end
      end
      LSC_LINK_UP: begin
        if (!link_up) begin
          lat_state_nxt = LSC_LINK_DOWN;
        end
      end
      default: begin
        lat_state_nxt = LSC_LINK_DOWN;
      end
    endcase
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      lat_state_r <= LSC_LINK_DOWN;
      lat_cap_r <= 10'h000;
      range_ok_r <= 1'b0;
    end else begin
      lat_state_r <= lat_state_nxt;
      lat_cap_r <= lat_cap_nxt;
      range_ok_r <= range_ok_nxt;
    end
  end

  // Holding tells the datapath not to realign its FIFO while the link is up
  assign latency_hold = (lat_state_r == LSC_LINK_UP);

  // Events: pin rises, latency drift on a live link, out-of-window capture
  always_comb begin
    prev_ind_nxt = {ch_b.ind, ch_a.ind};
    irq_set = 4'h0;
    irq_set[`LSC_IRQ_LOSS_A] = ch_a.ind & ~prev_ind_r[0];
    irq_set[`LSC_IRQ_LOSS_B] = ch_b.ind & ~prev_ind_r[1];
    irq_set[`LSC_IRQ_DRIFT] = (lat_state_r == LSC_LINK_UP) && (measured_latency_ui != lat_cap_r);
    irq_set[`LSC_IRQ_RANGE] = capture && cfg_full_rate_4lane && !lsc_in_range(measured_latency_ui);
    irq_st_nxt = irq_st_r;
    if (wr_go && (avs_address == `LSC_IRQ_ST_OFS) && avs_byteenable[0]) begin
      irq_st_nxt = irq_st_r & ~avs_writedata[`LSC_IRQ_W-1:0];
    end
    irq_st_nxt = irq_st_nxt | irq_set; // A new event outlives a clear in the same cycle
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      irq_st_r <= `LSC_IRQ_RST;
      prev_ind_r <= 2'b00;
    end else begin
      irq_st_r <= irq_st_nxt;
      prev_ind_r <= prev_ind_nxt;
    end
  end

  assign irq = |(irq_st_r & irq_mask_r);

  status_read_a: assert property (@(posedge clk_sys) disable iff (reset)
    (avs_read && !avs_waitrequest && avs_address == `LSC_STATUS_OFS) |-> avs_readdata == $past(status_live))
    else $error("status read does not match live indications");
  lat_frozen_a: assert property (@(posedge clk_sys) disable iff (reset)
    (lat_state_r == LSC_LINK_UP && $past(lat_state_r) == LSC_LINK_UP) |-> $stable(lat_cap_r))
    else $error("latency changed on a live link");
  hold_follows_a: assert property (@(posedge clk_sys) disable iff (reset)
    (!latency_hold && link_up) |=> latency_hold ##0 lat_cap_r == $past(measured_latency_ui))
    else $error("latency not captured at link establishment");
  range_flag_a: assert property (@(posedge clk_sys) disable iff (reset)
    (capture && cfg_full_rate_4lane) |=> range_ok_r == lsc_in_range($past(measured_latency_ui)))
    else $error("latency window flag wrong");
  chan_indep_a: assert property (@(posedge clk_sys) disable iff (reset)
    (wr_go && avs_address == `LSC_CTRL_A_OFS) |=> $stable(ctrl_b_r))
    else $error("channel A write touched channel B enables");
  bus_answer_a: assert property (@(posedge clk_sys) disable iff (reset)
    (bus_req && avs_waitrequest) |=> !avs_waitrequest || !bus_req)
    else $error("bus answer late");
endmodule

// ---- design/lsc_consts.svh ----
`ifndef LSC_CONSTS_SVH
`define LSC_CONSTS_SVH
// Contract
// - Loss pin per channel from signal-detect, off
// - Enabled channel sync loss ORed into pin
// - Enabled LS or HS PLL unlock ORed in
// - Enabled 8b/10b decode error ORed in
// - Enabled inverted gain lock ORed in
// - Enabled inverted offset calibration done ORed in
// - Loss indications readable over management registers
// - Latency fixed while link stays established
// - Full-rate four-lane latency within 554..814 UI

// Register byte offsets
`define LSC_CTRL_A_OFS 8'h00
`define LSC_CTRL_B_OFS 8'h04
`define LSC_STATUS_OFS 8'h08
`define LSC_IRQ_ST_OFS 8'h0C
`define LSC_IRQ_MASK_OFS 8'h10
`define LSC_LATENCY_OFS 8'h14

// Enable field positions inside each channel control register
`define LSC_EN_LOS 0
`define LSC_EN_SYNC 1
`define LSC_EN_PLL 2
`define LSC_EN_DEC 3
`define LSC_EN_AGC 4
`define LSC_EN_AZ 5
`define LSC_EN_W 6
`define LSC_CTRL_RST 6'h00

// Live status layout, channel B sits one byte above channel A
`define LSC_ST_B_SHIFT 8
`define LSC_ST_IND 7

// Interrupt bits
`define LSC_IRQ_LOSS_A 0
`define LSC_IRQ_LOSS_B 1
`define LSC_IRQ_DRIFT 2
`define LSC_IRQ_RANGE 3
`define LSC_IRQ_W 4
`define LSC_IRQ_RST 4'h0

// Latency window in unit intervals, full rate, four lanes, eight-deep FIFO
`define LSC_LAT_W 10
`define LSC_LAT_MIN_UI 10'h22A
`define LSC_LAT_MAX_UI 10'h32E
`define LSC_FIFO_DEPTH 8
`define LSC_LAT_LOCK_BIT 16
`define LSC_LAT_OK_BIT 17

// Analog condition inputs synchronised per channel
`define LSC_ASYNC_W 5
`endif

// ---- design/lsc_pkg.sv ----
package lsc_pkg;
  typedef logic [5:0] lsc_en_t;
  typedef logic [9:0] lsc_lat_t;
  // Link latency tracking
  typedef enum logic [1:0] {
    LSC_LINK_DOWN = 2'b00,
    LSC_LINK_UP = 2'b01
  } lsc_link_t;
endpackage

// ---- design/lsc_chan_if.sv ----
`timescale 1ns/1ps
interface lsc_chan_if;
  import lsc_pkg::*;
  lsc_en_t en;
  logic los;
  logic sync_lost;
  logic pll_ls_lost;
  logic pll_hs_lost;
  logic dec_err;
  logic gain_adapt_locked;
  logic offset_cal_done;
  logic ind;
  // Combiner side
  modport chan (
    input en,
    input los,
    input sync_lost,
    input pll_ls_lost,
    input pll_hs_lost,
    input dec_err,
    input gain_adapt_locked,
    input offset_cal_done,
    output ind
  );
  // Register side
  modport ctl (
    output en,
    output los,
    output sync_lost,
    output pll_ls_lost,
    output pll_hs_lost,
    output dec_err,
    output gain_adapt_locked,
    output offset_cal_done,
    input ind
  );
endinterface

// ---- design/lsc_chan.sv ----
`timescale 1ns/1ps
`include "lsc_consts.svh"
module lsc_chan import lsc_pkg::*; (
  input wire logic clk_sys,
  input wire logic reset,
  lsc_chan_if.chan ch
);
  logic ind_r;
  logic ind_nxt;

  // OR of every enabled contributor; inverted flags raise the pin when not good
  always_comb begin
    ind_nxt = 1'b0;
    ind_nxt = ind_nxt | (ch.en[`LSC_EN_LOS] & ch.los);
    ind_nxt = ind_nxt | (ch.en[`LSC_EN_SYNC] & ch.sync_lost);
    ind_nxt = ind_nxt | (ch.en[`LSC_EN_PLL] & (ch.pll_ls_lost | ch.pll_hs_lost));
    ind_nxt = ind_nxt | (ch.en[`LSC_EN_DEC] & ch.dec_err);
    ind_nxt = ind_nxt | (ch.en[`LSC_EN_AGC] & ~ch.gain_adapt_locked);
    ind_nxt = ind_nxt | (ch.en[`LSC_EN_AZ] & ~ch.offset_cal_done);
  end

  // Registered so the pin never glitches between contributors
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      ind_r <= 1'b0;
    end else begin
      ind_r <= ind_nxt;
    end
  end

  assign ch.ind = ind_r;

  los_path_a: assert property (@(posedge clk_sys) disable iff (reset)
    (ch.en[`LSC_EN_LOS] && ch.los) |=> ch.ind) else $error("signal-detect loss not shown");
  sync_path_a: assert property (@(posedge clk_sys) disable iff (reset)
    (ch.en[`LSC_EN_SYNC] && ch.sync_lost) |=> ch.ind) else $error("sync loss not shown");
  pll_path_a: assert property (@(posedge clk_sys) disable iff (reset)
    (ch.en[`LSC_EN_PLL] && (ch.pll_ls_lost || ch.pll_hs_lost)) |=> ch.ind) else $error("pll loss not shown");
  dec_path_a: assert property (@(posedge clk_sys) disable iff (reset)
    (ch.en[`LSC_EN_DEC] && ch.dec_err) |=> ch.ind) else $error("decode error not shown");
  agc_path_a: assert property (@(posedge clk_sys) disable iff (reset)
    (ch.en[`LSC_EN_AGC] && !ch.gain_adapt_locked) |=> ch.ind) else $error("gain unlock not shown");
  az_path_a: assert property (@(posedge clk_sys) disable iff (reset)
    (ch.en[`LSC_EN_AZ] && !ch.offset_cal_done) |=> ch.ind) else $error("calibration not shown");
  quiet_off_a: assert property (@(posedge clk_sys) disable iff (reset)
    (ch.en == `LSC_CTRL_RST) |=> !ch.ind) else $error("pin high with all enables off");
endmodule

// ---- sim/lsc_sys_mon.sv ----
`timescale 1ns/1ps
// Far-side system monitor: it only watches the two loss pins and counts rising edges
module lsc_sys_mon (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic loss_a,
  input wire logic loss_b,
  output int rise_a,
  output int rise_b
);
  logic prev_a, prev_b;
  // Counting edges rather than levels counts a pin that stays stuck high only once
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      prev_a <= 1'b0;
      prev_b <= 1'b0;
      rise_a <= 0;
      rise_b <= 0;
    end else begin
      prev_a <= loss_a;
      prev_b <= loss_b;
      if (loss_a && !prev_a) rise_a <= rise_a + 1;
      if (loss_b && !prev_b) rise_b <= rise_b + 1;
    end
  end
endmodule

// ---- sim/lsc_top_tb.sv ----
`timescale 1ns/1ps
module lsc_top_tb;
  import lsc_pkg::*;
  logic clk_sys, reset, avs_read, avs_write, avs_waitrequest, irq, latency_hold;
  logic [7:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, rd;
  logic [6:0] bad_a, bad_b;
  logic link_up, cfg_full_rate_4lane, loss_a, loss_b;
  logic [9:0] measured_latency_ui;
  int error_cnt, check_count, rise_a, rise_b, eb;

  // Conditions held as "bad" flags; lock and calibration flags are the inverse
  lsc_top u_lsc_top (.clk_sys(clk_sys), .reset(reset), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hF), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .sig_det_loss_a(bad_a[0]), .sync_lost_a(bad_a[1]),
    .pll_ls_lost_a(bad_a[2]), .dec_err_a(bad_a[3]), .gain_adapt_locked_a(~bad_a[4]),
    .offset_cal_done_a(~bad_a[5]), .pll_hs_lost_a(bad_a[6]), .sig_det_loss_b(bad_b[0]),
    .sync_lost_b(bad_b[1]), .pll_ls_lost_b(bad_b[2]), .dec_err_b(bad_b[3]), .gain_adapt_locked_b(~bad_b[4]),
    .offset_cal_done_b(~bad_b[5]), .pll_hs_lost_b(bad_b[6]), .link_up(link_up),
    .cfg_full_rate_4lane(cfg_full_rate_4lane), .measured_latency_ui(measured_latency_ui),
    .latency_hold(latency_hold), .loss_indicator_chan_a(loss_a), .loss_indicator_chan_b(loss_b), .irq(irq));

  lsc_sys_mon u_lsc_sys_mon (.clk_sys(clk_sys), .reset(reset), .loss_a(loss_a), .loss_b(loss_b),
    .rise_a(rise_a), .rise_b(rise_b));

  // Clock at 50 MHz
  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("FAIL %s expected %h seen %h", name, exp, got);
    end
  endtask

  // One bus cycle; the request stands until the rising edge at which waitrequest is sampled low
  task automatic bus(input logic wr, input logic [7:0] addr, input logic [31:0] data);
    @(posedge clk_sys);
    avs_address <= addr;
    avs_writedata <= data;
    avs_write <= wr;
    avs_read <= ~wr;
    do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask

  task automatic wt(input int n);
    repeat (n) @(posedge clk_sys);
  endtask

  task automatic summarize;
    $display("Checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // Watchdog: the tests need well under a thousand cycles
  initial begin
    #200000;
    error_cnt++;
    summarize();
  end

  initial begin
    reset = 1'b1;
    {avs_read, avs_write, link_up, cfg_full_rate_4lane} = 4'h0;
    avs_address = 8'h00;
    avs_writedata = 32'h00000000;
    bad_a = 7'h00;
    bad_b = 7'h00;
    measured_latency_ui = 10'h000;
    error_cnt = 0;
    check_count = 0;
    repeat (6) @(posedge clk_sys);
    reset <= 1'b0;
    // Every contributor off after reset, even with all conditions bad
    bus(0, `LSC_CTRL_A_OFS, 0); chk("ctrl_a", 32'h0, rd);
    bus(0, `LSC_CTRL_B_OFS, 0); chk("ctrl_b", 32'h0, rd);
    bus(0, `LSC_IRQ_MASK_OFS, 0); chk("mask", 32'h0, rd);
    bad_a <= 7'h7F;
    bad_b <= 7'h7F;
    wt(5);
    chk("pin_a_off", 32'h0, {31'h0, loss_a});
    chk("pin_b_off", 32'h0, {31'h0, loss_b});
    bad_a <= 7'h00;
    bad_b <= 7'h00;
    wt(5);
    // One condition at a time; channel B enables all others, so only A may rise
    for (int k = 0; k < 7; k++) begin
      eb = (k == 6) ? 2 : k;
      bus(1, `LSC_CTRL_A_OFS, 32'h1 << eb);
      bus(1, `LSC_CTRL_B_OFS, 32'h3F ^ (32'h1 << eb));
      bad_a <= 7'h01 << k;
      bad_b <= 7'h01 << k;
      wt(5);
      chk("pin_a_on", 32'h1, {31'h0, loss_a});
      chk("pin_b_other", 32'h0, {31'h0, loss_b});
      bad_a <= 7'h00;
      bad_b <= 7'h00;
      wt(5);
      chk("pin_a_clear", 32'h0, {31'h0, loss_a});
    end
    chk("mon_rise_a", 32'd7, rise_a);
    chk("mon_rise_b", 32'd0, rise_b);
    // Status readback and the pin-rise interrupt
    bus(1, `LSC_CTRL_B_OFS, 32'h0);
    bus(1, `LSC_CTRL_A_OFS, 32'h1);
    bus(1, `LSC_IRQ_ST_OFS, 32'hF);
    bad_a <= 7'h01;
    wt(5);
    bus(0, `LSC_STATUS_OFS, 0); chk("status", 32'h60E1, rd);
    bus(0, `LSC_IRQ_ST_OFS, 0); chk("irq_st", 32'h1, rd);
    chk("irq_masked", 32'h0, {31'h0, irq});
    bus(1, `LSC_IRQ_MASK_OFS, 32'h1);
    wt(1);
    chk("irq_on", 32'h1, {31'h0, irq});
    bus(1, `LSC_IRQ_ST_OFS, 32'h1);
    wt(1);
    chk("irq_off", 32'h0, {31'h0, irq});
    bus(0, `LSC_IRQ_ST_OFS, 0); chk("irq_st_clr", 32'h0, rd);
    bad_a <= 7'h00;
    bus(0, 8'h20, 0); chk("unmapped", 32'h0, rd);
    // Latency captured at link up and frozen while up
    cfg_full_rate_4lane <= 1'b1;
    measured_latency_ui <= 10'h258;
    link_up <= 1'b1;
    wt(3);
    chk("hold", 32'h1, {31'h0, latency_hold});
    bus(0, `LSC_LATENCY_OFS, 0); chk("lat", 32'h30258, rd);
    measured_latency_ui <= 10'h259;
    wt(3);
    bus(0, `LSC_LATENCY_OFS, 0); chk("lat_frozen", 32'h30258, rd);
    bus(0, `LSC_IRQ_ST_OFS, 0); chk("drift", 32'h4, rd & 32'h4);
    // Range bounds: lower edge inside, one above upper edge outside
    link_up <= 1'b0;
    measured_latency_ui <= 10'h22A;
    wt(3);
    chk("hold_down", 32'h0, {31'h0, latency_hold});
    link_up <= 1'b1;
    wt(3);
    bus(0, `LSC_LATENCY_OFS, 0); chk("lat_min", 32'h3022A, rd);
    link_up <= 1'b0;
    measured_latency_ui <= 10'h32F;
    wt(3);
    bus(1, `LSC_IRQ_ST_OFS, 32'hF);
    link_up <= 1'b1;
    wt(3);
    bus(0, `LSC_LATENCY_OFS, 0); chk("lat_high", 32'h1032F, rd);
    bus(0, `LSC_IRQ_ST_OFS, 0); chk("range_irq", 32'h8, rd);
    summarize();
  end
endmodule
